// *** core/bsp_pkg.sv ***
package bsp_pkg;
  localparam int CHAN_W = 16;
  localparam int NUM_MAC = 12;
  localparam int CODE_W = 4;
  // connect code rides in bits C through F of output channel 6
  localparam int CODE_LSB = 12;
  // scanner select bit is bit B of output channel 6
  localparam int SCAN_BIT = 11;
  localparam logic [3:0] IDLE_CODE = 4'hf;
  localparam logic [3:0] SCAN_CODE_DEF = 4'h6;
  localparam logic [31:0] CODE_TABLE_DEF = 32'h8754_3210;
  localparam int NUM_IF_DEF = 8;
  // interface status bits on input channel 5
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_ABNORMAL = 3;
  localparam int ST_EXT_W = 12;
  // controller register map, byte addresses
  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_NOC5 = 8'h04;
  localparam logic [7:0] ADDR_NOC6 = 8'h08;
  localparam logic [7:0] ADDR_NOC7 = 8'h0c;
  localparam logic [7:0] ADDR_NIC5 = 8'h10;
  localparam logic [7:0] ADDR_NIC6 = 8'h14;
  localparam logic [7:0] ADDR_NIC7 = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_HOLD = 4;
  localparam int SEL_SCAN = 5;
  localparam int SEL_W = 6;
  localparam int NOC6_DATA_W = 11;
  localparam int NUM_EV = 3;
  localparam logic [5:0] SEL_RESET = 6'h0f;
  typedef enum logic [1:0] {
    SCAN_BY_CODE,
    SCAN_BY_BIT,
    SCAN_ABSENT
  } bsp_scan_mode_e;
endpackage : bsp_pkg

// *** core/bsp_if.sv ***
`timescale 1ns/1ns
interface bsp_if;
  logic [15:0] noc5;
  logic [15:0] noc6;
  logic [15:0] noc7;
  logic [15:0] nic5;
  logic [15:0] nic6;
  logic [15:0] nic7;
  modport dev
  (
    input noc5, noc6, noc7,
    output nic5, nic6, nic7
  );
  modport host
  (
    output noc5, noc6, noc7,
    input nic5, nic6, nic7
  );
endinterface : bsp_if

// *** core/bsp_station_buffer_unit.sv ***
// Notes on behaviour
// - several interfaces transfer to memory concurrently
// - controller may start another before first ends
// - software keeps interface buffer regions apart
// - controller presents connect code before access
// - matching interface attaches, all others detach
// - attached only while code stays presented
// - connect code on output channel 6 bits C-F
// - status on input channels only when selected
// - busy, done, parity, abnormal as separate bits
// - 16-bit scanner word, busy and done per interface
// - scanner word shown only while requested
// - scanner code also on channel 6 bits C-F
// - scanner input channel fixed per unit variant
// - access channel priorities 0 to 11, 0 highest
// - network grants only highest pending request
// - fixed-rate devices wired to high priorities
// - three output and three input 16-bit channels
`timescale 1ns/1ns
module bsp_station_buffer_unit #(
  parameter int NUM_IF = bsp_pkg::NUM_IF_DEF,
  parameter logic [31:0] CODE_TABLE = bsp_pkg::CODE_TABLE_DEF,
  parameter bsp_pkg::bsp_scan_mode_e SCAN_MODE = bsp_pkg::SCAN_BY_CODE,
  parameter logic [3:0] SCAN_CODE = bsp_pkg::SCAN_CODE_DEF,
  parameter int SCAN_NIC = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  bsp_if.dev chan,
  input wire logic [NUM_IF-1:0] if_busy,
  input wire logic [NUM_IF-1:0] if_done,
  input wire logic [NUM_IF-1:0] if_parity_err,
  input wire logic [NUM_IF-1:0] if_abnormal,
  input wire logic [NUM_IF*bsp_pkg::ST_EXT_W-1:0] if_ext5,
  input wire logic [NUM_IF*bsp_pkg::CHAN_W-1:0] if_ext6,
  input wire logic [NUM_IF*bsp_pkg::CHAN_W-1:0] if_ext7,
  output logic [NUM_IF-1:0] if_attach,
  output logic [15:0] ctl5,
  output logic [15:0] ctl6,
  output logic [15:0] ctl7,
  input wire logic [bsp_pkg::NUM_MAC-1:0] mac_req,
  output logic [bsp_pkg::NUM_MAC-1:0] mac_grant
);

  logic [3:0] code;
  logic scan_hit;
  logic [NUM_IF-1:0] attach_d;
  logic [NUM_IF-1:0] attach_q;
  logic any_attach;
  logic [15:0] scan_word;
  logic [15:0] st5;
  logic [15:0] st6;
  logic [15:0] st7;
  logic [15:0] nic5_d;
  logic [15:0] nic6_d;
  logic [15:0] nic7_d;
  logic [15:0] nic5_q;
  logic [15:0] nic6_q;
  logic [15:0] nic7_q;
  logic [15:0] ctl5_q;
  logic [15:0] ctl6_q;
  logic [15:0] ctl7_q;

  // one-hot of interfaces whose connect code equals the presented one
  function automatic logic [NUM_IF-1:0] match_code(input logic [3:0] c);
    logic [NUM_IF-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_IF; i++)
    begin
      m[i] = (CODE_TABLE[i*4 +: 4] == c);
    end
    return m;
  endfunction : match_code

  // OR of the selected interface's word; zero when none selected
  function automatic logic [15:0] pick_word(
    input logic [NUM_IF-1:0] sel,
    input logic [NUM_IF*16-1:0] words
  );
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < NUM_IF; i++)
    begin
      if (sel[i])
      begin
        w = w | words[i*16 +: 16];
      end
    end
    return w;
  endfunction : pick_word

  // lowest channel number among pending requests wins
  function automatic logic [bsp_pkg::NUM_MAC-1:0] prio_grant(
    input logic [bsp_pkg::NUM_MAC-1:0] req
  );
    logic [bsp_pkg::NUM_MAC-1:0] g;
    g = '0;
    for (int i = bsp_pkg::NUM_MAC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction : prio_grant

  assign code = chan.noc6[bsp_pkg::CODE_LSB +: bsp_pkg::CODE_W];

  // scanner request by code or bit
  always_comb
  begin
    case (SCAN_MODE)
      bsp_pkg::SCAN_BY_CODE: scan_hit = (code == SCAN_CODE);
      bsp_pkg::SCAN_BY_BIT: scan_hit = chan.noc6[bsp_pkg::SCAN_BIT];
      default: scan_hit = 1'b0;
    endcase
  end

  assign attach_d = match_code(code);
  assign any_attach = |attach_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      attach_q <= '0;
    end
    else
    begin
      attach_q <= attach_d;
    end
  end

  // control words pass on only while some interface is attached, else zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl5_q <= 16'h0000;
      ctl6_q <= 16'h0000;
      ctl7_q <= 16'h0000;
    end
    else
    begin
      ctl5_q <= any_attach ? chan.noc5 : 16'h0000;
      ctl6_q <= any_attach ? chan.noc6 : 16'h0000;
      ctl7_q <= any_attach ? chan.noc7 : 16'h0000;
    end
  end

  // individual condition bits in channel 5 status
  logic [NUM_IF*16-1:0] w5;
  // scanner word: busy and done per interface
  generate
    for (genvar i = 0; i < NUM_IF; i++)
    begin : g_if
      assign w5[i*16 +: 16] = {
        if_ext5[i*bsp_pkg::ST_EXT_W +: bsp_pkg::ST_EXT_W],
        if_abnormal[i], if_parity_err[i], if_done[i], if_busy[i]
      };
      assign scan_word[2*i] = if_busy[i];
      assign scan_word[2*i+1] = if_done[i];
    end
    for (genvar j = 2 * NUM_IF; j < 16; j++)
    begin : g_pad
      assign scan_word[j] = 1'b0;
    end
  endgenerate

  // status only from the selected interface
  assign st5 = pick_word(attach_d, w5);
  assign st6 = pick_word(attach_d, if_ext6);
  assign st7 = pick_word(attach_d, if_ext7);

  // scanner lands on the variant's channel
  always_comb
  begin
    nic5_d = st5;
    nic6_d = st6;
    nic7_d = st7;
    if (scan_hit)
    begin
      nic5_d = (SCAN_NIC == 5) ? scan_word : 16'h0000;
      nic6_d = (SCAN_NIC == 6) ? scan_word : 16'h0000;
      nic7_d = (SCAN_NIC == 7) ? scan_word : 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nic5_q <= 16'h0000;
      nic6_q <= 16'h0000;
      nic7_q <= 16'h0000;
    end
    else
    begin
      nic5_q <= nic5_d;
      nic6_q <= nic6_d;
      nic7_q <= nic7_d;
    end
  end

  assign chan.nic5 = nic5_q;
  assign chan.nic6 = nic6_q;
  assign chan.nic7 = nic7_q;
  assign if_attach = attach_q;
  assign ctl5 = ctl5_q;
  assign ctl6 = ctl6_q;
  assign ctl7 = ctl7_q;

  // channel index is its priority number
  // single grant per cycle to the best
  // fast devices wired to low indices
  // losers keep request, granted when clear
  assign mac_grant = prio_grant(mac_req);

endmodule : bsp_station_buffer_unit

// *** core/bsp_station_control_processor.sv ***
`timescale 1ns/1ns
module bsp_station_control_processor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  bsp_if.host chan
);

  logic [bsp_pkg::SEL_W-1:0] sel_q;
  logic [15:0] noc5_q;
  logic [bsp_pkg::NOC6_DATA_W-1:0] noc6_q;
  logic [15:0] noc7_q;
  logic [15:0] nic5_q;
  logic [15:0] nic6_q;
  logic [15:0] nic7_q;
  logic [bsp_pkg::NUM_EV-1:0] stat_q;
  logic [bsp_pkg::NUM_EV-1:0] en_q;
  logic [bsp_pkg::NUM_EV-1:0] ev;
  logic [bsp_pkg::NUM_EV-1:0] clr;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic mapped;
  logic wr;
  logic [3:0] code_out;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      bsp_pkg::ADDR_SEL: rd_mux = {26'h0, sel_q};
      bsp_pkg::ADDR_NOC5: rd_mux = {16'h0, noc5_q};
      bsp_pkg::ADDR_NOC6: rd_mux = {21'h0, noc6_q};
      bsp_pkg::ADDR_NOC7: rd_mux = {16'h0, noc7_q};
      bsp_pkg::ADDR_NIC5: rd_mux = {16'h0, nic5_q};
      bsp_pkg::ADDR_NIC6: rd_mux = {16'h0, nic6_q};
      bsp_pkg::ADDR_NIC7: rd_mux = {16'h0, nic7_q};
      bsp_pkg::ADDR_IRQ_STAT: rd_mux = {29'h0, stat_q};
      bsp_pkg::ADDR_IRQ_CLR: rd_mux = 32'h0000_0000;
      bsp_pkg::ADDR_IRQ_EN: rd_mux = {29'h0, en_q};
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign clr = (wr && paddr == bsp_pkg::ADDR_IRQ_CLR) ?
               pwdata[bsp_pkg::NUM_EV-1:0] : '0;

  // read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= bsp_pkg::SEL_RESET;
      noc5_q <= 16'h0000;
      noc6_q <= '0;
      noc7_q <= 16'h0000;
      en_q <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        bsp_pkg::ADDR_SEL: sel_q <= pwdata[bsp_pkg::SEL_W-1:0];
        bsp_pkg::ADDR_NOC5: noc5_q <= pwdata[15:0];
        bsp_pkg::ADDR_NOC6: noc6_q <= pwdata[bsp_pkg::NOC6_DATA_W-1:0];
        bsp_pkg::ADDR_NOC7: noc7_q <= pwdata[15:0];
        bsp_pkg::ADDR_IRQ_EN: en_q <= pwdata[bsp_pkg::NUM_EV-1:0];
        default: en_q <= en_q;
      endcase
    end
  end

  // code presented only while hold is set
  assign code_out = sel_q[bsp_pkg::SEL_HOLD] ?
                    sel_q[bsp_pkg::SEL_CODE_LSB +: 4] : bsp_pkg::IDLE_CODE;
  // code on bits C-F, scanner bit on B
  assign chan.noc6 = {code_out, sel_q[bsp_pkg::SEL_SCAN], noc6_q};
  assign chan.noc5 = noc5_q;
  assign chan.noc7 = noc7_q;

  // input channel samples and change events
  assign ev = {chan.nic7 != nic7_q, chan.nic6 != nic6_q,
               chan.nic5 != nic5_q};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nic5_q <= 16'h0000;
      nic6_q <= 16'h0000;
      nic7_q <= 16'h0000;
    end
    else
    begin
      nic5_q <= chan.nic5;
      nic6_q <= chan.nic6;
      nic7_q <= chan.nic7;
    end
  end

  // sticky status, a new event beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end
  assign irq = |(stat_q & en_q);

endmodule : bsp_station_control_processor

// *** verification/bsp_monitor.sv ***
`timescale 1ns/1ns
module bsp_monitor #(
  parameter int NUM_IF = bsp_pkg::NUM_IF_DEF,
  parameter logic [31:0] CODE_TABLE = bsp_pkg::CODE_TABLE_DEF,
  parameter logic [3:0] SCAN_CODE = bsp_pkg::SCAN_CODE_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] noc6,
  input wire logic [15:0] nic5,
  input wire logic [15:0] nic6,
  input wire logic [15:0] nic7,
  input wire logic [NUM_IF-1:0] if_busy,
  input wire logic [NUM_IF-1:0] if_done,
  input wire logic [NUM_IF-1:0] if_parity_err,
  input wire logic [NUM_IF-1:0] if_abnormal,
  input wire logic [NUM_IF*12-1:0] if_ext5,
  input wire logic [NUM_IF*16-1:0] if_ext6,
  input wire logic [NUM_IF*16-1:0] if_ext7,
  input wire logic [NUM_IF-1:0] if_attach,
  input wire logic [11:0] mac_req,
  input wire logic [11:0] mac_grant
);
  logic [NUM_IF-1:0] at_d, at_q;
  logic [15:0] e5_d, e6_d, e7_d, e5_q, e6_q, e7_q;
  logic up_q, scan_q;
  // reference of what the unit shows one edge later
  always_comb
  begin
    at_d = '0;
    e5_d = '0;
    e6_d = '0;
    e7_d = '0;
    for (int i = 0; i < NUM_IF; i++)
    begin
      if (noc6[15:12] == CODE_TABLE[4*i +: 4])
      begin
        at_d[i] = 1'b1;
        e5_d = {if_ext5[12*i +: 12], if_abnormal[i], if_parity_err[i],
          if_done[i], if_busy[i]};
        e6_d = if_ext6[16*i +: 16];
        e7_d = if_ext7[16*i +: 16];
      end
    end
  end
  always_ff @(posedge pclk)
  begin
    at_q <= at_d;
    e5_q <= e5_d;
    e6_q <= e6_d;
    e7_q <= e7_d;
    scan_q <= noc6[15:12] == SCAN_CODE;
    for (int i = 0; i < NUM_IF; i++)
    begin
      if (noc6[15:12] == SCAN_CODE)
      begin
        e6_q[2*i] <= if_busy[i];
        e6_q[2*i+1] <= if_done[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_q <= 1'b0;
    else
      up_q <= 1'b1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_scan_held;
    up_q && scan_q;
  endsequence
  sequence s_scan_gone;
    !scan_q && at_q == '0;
  endsequence
  a_grant_lowest: assert property (
    mac_grant == (mac_req & (~mac_req + 12'h001)))
    else $error("grant is not the lowest request");
  a_one_grant: assert property (
    mac_req != 12'h000 |-> $onehot(mac_grant))
    else $error("pending request without one grant");
  a_attach_match: assert property (
    up_q |-> if_attach == at_q)
    else $error("attach does not follow code");
  a_attach_onehot: assert property (
    $onehot0(if_attach))
    else $error("more than one interface attached");
  a_status_sel: assert property (
    up_q && at_q != '0 |-> nic5 == e5_q && nic6 == e6_q && nic7 == e7_q)
    else $error("selected status wrong");
  a_unmatched_zero: assert property (
    up_q && at_q == '0 && !scan_q |-> (nic5 | nic6 | nic7) == 16'h0000)
    else $error("input channels not zero");
  a_scan_word: assert property (
    s_scan_held |-> nic6 == e6_q && (nic5 | nic7) == 16'h0000)
    else $error("scanner word wrong");
  a_scan_drop: assert property (
    s_scan_held ##1 s_scan_gone |-> nic6 == 16'h0000)
    else $error("scanner word kept");
endmodule : bsp_monitor

// *** verification/buffer_unit_select_and_priority_test.sv ***
`timescale 1ns/1ns
module buffer_unit_select_and_priority_test;
  localparam int N = bsp_pkg::NUM_IF_DEF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [N-1:0] busy, done, par, abn, attach;
  logic [N*12-1:0] ext5;
  logic [N*16-1:0] ext6, ext7;
  logic [15:0] ctl5, ctl6, ctl7;
  logic [11:0] mreq, mgnt;
  int error_cnt, checked;
  bsp_if bsp_if_i();
  bsp_station_buffer_unit bsp_station_buffer_unit_i (.pclk(pclk),
    .presetn(presetn), .chan(bsp_if_i.dev), .if_busy(busy),
    .if_done(done), .if_parity_err(par), .if_abnormal(abn),
    .if_ext5(ext5), .if_ext6(ext6), .if_ext7(ext7), .if_attach(attach),
    .ctl5(ctl5), .ctl6(ctl6), .ctl7(ctl7), .mac_req(mreq), .mac_grant(mgnt));
  bsp_station_control_processor bsp_station_control_processor_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chan(bsp_if_i.host));
  bsp_monitor bsp_monitor_i (.pclk(pclk), .presetn(presetn),
    .noc6(bsp_if_i.noc6), .nic5(bsp_if_i.nic5), .nic6(bsp_if_i.nic6),
    .nic7(bsp_if_i.nic7), .if_busy(busy), .if_done(done),
    .if_parity_err(par), .if_abnormal(abn), .if_ext5(ext5),
    .if_ext6(ext6), .if_ext7(ext7), .if_attach(attach),
    .mac_req(mreq), .mac_grant(mgnt));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task t_regs;
    rdchk(bsp_pkg::ADDR_SEL, 32'h0f);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
  endtask : t_regs
  task t_select;
    for (int i = 0; i < N; i++)
    begin
      apb(1'b1, bsp_pkg::ADDR_SEL, 32'h10 | bsp_pkg::CODE_TABLE_DEF[4*i +: 4]);
      apb(1'b1, bsp_pkg::ADDR_NOC5, 32'h1230 + i);
      apb(1'b1, bsp_pkg::ADDR_NOC6, 32'h0450 + i);
      apb(1'b1, bsp_pkg::ADDR_NOC7, 32'h4560 + i);
      settle;
      check(attach, 32'h1 << i);
      check(ctl5, 32'h1230 + i);
      check({ctl6, ctl7}, {bsp_pkg::CODE_TABLE_DEF[4*i +: 4], 1'b0,
        11'h450 + 11'(i), 16'h4560 + 16'(i)});
      rdchk(bsp_pkg::ADDR_NIC5, {ext5[12*i +: 12], abn[i], par[i],
        done[i], busy[i]});
      rdchk(bsp_pkg::ADDR_NIC7, ext7[16*i +: 16]);
    end
  endtask : t_select
  task t_unmatched;
    for (int c = 9; c < 16; c++)
    begin
      apb(1'b1, bsp_pkg::ADDR_SEL, 32'h10 | c);
      settle;
      check(attach, 32'h0);
      check({ctl6, ctl7}, 32'h0);
      rdchk(bsp_pkg::ADDR_NIC6, 32'h0);
    end
    apb(1'b1, bsp_pkg::ADDR_SEL, 32'h01);
    settle;
    check(attach, 32'h0);
  endtask : t_unmatched
  task t_scanner;
    logic [15:0] w;
    w = '0;
    for (int i = 0; i < N; i++)
      w[2*i +: 2] = {done[i], busy[i]};
    apb(1'b1, bsp_pkg::ADDR_SEL, 32'h16);
    settle;
    rdchk(bsp_pkg::ADDR_NIC6, w);
    rdchk(bsp_pkg::ADDR_NIC5, 32'h0);
    apb(1'b1, bsp_pkg::ADDR_SEL, 32'h00);
    settle;
    rdchk(bsp_pkg::ADDR_NIC6, 32'h0);
  endtask : t_scanner
  task t_irq;
    apb(1'b1, bsp_pkg::ADDR_IRQ_EN, 32'h1);
    apb(1'b1, bsp_pkg::ADDR_SEL, 32'h10);
    settle;
    apb(1'b1, bsp_pkg::ADDR_IRQ_CLR, 32'h7);
    busy[0] <= ~busy[0];
    settle;
    check(irq, 1'b1);
    rdchk(bsp_pkg::ADDR_IRQ_STAT, 32'h1);
    apb(1'b1, bsp_pkg::ADDR_IRQ_CLR, 32'h1);
    apb(1'b1, bsp_pkg::ADDR_IRQ_EN, 32'h0);
    busy[0] <= ~busy[0];
    settle;
    check(irq, 1'b0);
    rdchk(bsp_pkg::ADDR_IRQ_STAT, 32'h1);
    rdchk(bsp_pkg::ADDR_IRQ_CLR, 32'h0);
  endtask : t_irq
  task t_arbiter;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge pclk);
      mreq <= 12'hfff << i;
      @(negedge pclk);
      check(mgnt, 32'h1 << i);
    end
    @(posedge pclk);
    mreq <= 12'h006;
    @(negedge pclk);
    check(mgnt, 32'h2);
    @(posedge pclk);
    mreq <= 12'h004;
    @(negedge pclk);
    check(mgnt, 32'h4);
  endtask : t_arbiter
  task give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mreq} = '0;
    error_cnt = 0;
    checked = 0;
    for (int i = 0; i < N; i++)
    begin
      {abn[i], par[i], done[i], busy[i]} = 4'(i + 5);
      ext5[12*i +: 12] = 12'h0a0 + 12'(i);
      ext6[16*i +: 16] = 16'hc000 + 16'(i);
      ext7[16*i +: 16] = 16'h2f00 + 16'(i * 17);
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_select;
    t_unmatched;
    t_scanner;
    t_irq;
    t_arbiter;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict;
  end
endmodule : buffer_unit_select_and_priority_test
